// [dcs_defs.svh]
// constants shared by both ends of the daisy-chain command port
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

// word layout
`define DCS_W 16
`define DCS_B_BIT 15
`define DCS_S_BIT 14
`define DCS_POS_HI 13
`define DCS_POS_LO 8
`define DCS_RW_BIT 15
`define DCS_POS_ALL 6'h00
`define DCS_POS_EACH 6'h3f

// device-side registers handled inside the port
`define DCS_CFG_ADDR 15'h0001
`define DCS_CKS_BIT 0
`define DCS_STAT_ADDR 15'h03ff
`define DCS_FAULT_BIT 3

// timing
`define DCS_CLK_NS 40
`define DCS_LINK_NS 320
`define DCS_HALF_CYC ((`DCS_LINK_NS / `DCS_CLK_NS) / 2)
`define DCS_SYNC_NS 1000
`define DCS_SYNC_CYC ((`DCS_SYNC_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)

// host controller register map
`define DCS_H_CTRL 4'h0
`define DCS_H_TX 4'h1
`define DCS_H_RX 4'h2
`define DCS_H_CSUM 4'h3
`define DCS_H_END_BIT 0
`define DCS_H_SYNC_BIT 1
`define DCS_H_ERRCLR_BIT 2
`define DCS_H_DUM_HI 15
`define DCS_H_DUM_LO 8
`define DCS_H_BUSY_BIT 0
`define DCS_H_CS_BIT 1
`define DCS_H_ERR_BIT 2

`endif

// [dcs_pkg.sv]
// state types of the daisy-chain command port
package dcs_pkg;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_HDR = 3'b001,
    DS_CNT = 3'b010,
    DS_ADDR = 3'b011,
    DS_DATA = 3'b100,
    DS_CSUM = 3'b101,
    DS_RSLOT = 3'b110,
    DS_SKIP = 3'b111
  } dcs_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LEAD = 2'b01,
    HS_SHIFT = 2'b10,
    HS_TAIL = 2'b11
  } dcs_host_state_t;

endpackage

// [dcs_link_if.sv]
// serial link between the host controller and one chained device
`timescale 1ns/100ps
interface dcs_link_if;
  logic sclk;
  logic cs_n;
  logic serial_input;
  logic serial_output;
  logic serial_output_oe;
  logic frame_sync;

  modport dev (
    input sclk,
    input cs_n,
    input serial_input,
    input frame_sync,
    output serial_output,
    output serial_output_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output serial_input,
    output frame_sync,
    input serial_output,
    input serial_output_oe
  );
endinterface

// [dcs_dev_end.sv]
// device end of the daisy-chain command port
//
// The implementer's own choices: strobed register access and the register offsets.
`include "dcs_defs.svh"
`timescale 1ns/100ps
module dcs_dev_end (
  input wire logic clk_in,
  input wire logic arst_n_in,
  dcs_link_if.dev link,
  input wire logic [5:0] chain_position_in,
  input wire logic [15:0] reg_rdata_in,
  output logic [14:0] reg_addr_out,
  output logic [15:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic xfer_ok_out,
  output logic xfer_bad_out,
  output logic checksum_fault_out,
  output logic checksum_en_out,
  output logic frame_sync_out
);
  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [1:0] sin_s;
  logic [2:0] fs_s;
  logic [5:0] pos_s0;
  logic [5:0] pos_q;
  dcs_pkg::dcs_dev_state_t st_q;
  logic [3:0] bit_q;
  logic [15:0] dly_q;
  logic so_q;
  logic oe_q;
  logic sg_q;
  logic each_q;
  logic mine_q;
  logic [15:0] cnt_q;
  logic [14:0] addr_q;
  logic [15:0] sum_q;
  logic [15:0] wcnt_q;
  logic [5:0] slot_q;
  logic [15:0] rd_q;
  logic cks_en_q;
  logic fault_q;
  logic cfg_hit_q;
  logic cfg_val_q;

  // synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      sin_s <= 2'h0;
      fs_s <= 3'h0;
      pos_s0 <= 6'h00;
      pos_q <= 6'h00;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s <= {cs_s[1:0], link.cs_n};
      sin_s <= {sin_s[0], link.serial_input};
      fs_s <= {fs_s[1:0], link.frame_sync};
      pos_s0 <= chain_position_in;
      pos_q <= pos_s0;
    end
  end

  wire frame_w = ~cs_s[1];
  wire cs_fall_w = ~cs_s[1] & cs_s[2];
  wire rise_w = frame_w & sclk_s[1] & ~sclk_s[2];
  wire fall_w = frame_w & ~sclk_s[1] & sclk_s[2];
  wire word_w = rise_w & (bit_q == 4'hf);
  wire [15:0] wd_w = {dly_q[14:0], sin_s[1]};

  // header decode
  wire [5:0] hpos_w = wd_w[`DCS_POS_HI:`DCS_POS_LO];
  wire h_bc_w = wd_w[`DCS_B_BIT];
  wire h_all_w = h_bc_w & (hpos_w == `DCS_POS_ALL);
  wire h_each_w = h_bc_w & (hpos_w == `DCS_POS_EACH);
  wire pos_ok_w = (pos_q != `DCS_POS_ALL) & (pos_q != `DCS_POS_EACH);
  wire h_mine_w = ~h_bc_w & pos_ok_w & (hpos_w == pos_q);
  wire h_any_w = h_all_w | h_each_w | h_mine_w;

  // data slot bookkeeping
  wire [15:0] n_w = sg_q ? 16'h0001 : cnt_q;
  wire [5:0] tslot_w = each_q ? (pos_q - 6'h01) : 6'h00;
  wire take_w = (slot_q == tslot_w);
  wire last_w = (wcnt_q == (n_w - 16'h0001));
  wire [15:0] sum_nx_w = sum_q + wd_w;
  wire cks_ok_w = (sum_nx_w == 16'h0000);
  // per-device broadcast carries the other devices' words too, so the
  // checksum cannot be closed locally and is not applied there
  wire need_cks_w = cks_en_q & ~each_q;
  wire [14:0] waddr_w = addr_q + wcnt_q[14:0];

  wire in_addr_w = word_w & (st_q == dcs_pkg::DS_ADDR);
  wire rd_hit_w = in_addr_w & wd_w[`DCS_RW_BIT] & mine_q;
  wire rslot_w = word_w & (st_q == dcs_pkg::DS_RSLOT);
  wire sub_w = rslot_w & (~cks_en_q | cks_ok_w);
  wire [15:0] dly_d = sub_w ? rd_q :
                      rd_hit_w ? {1'b0, wd_w[14:0]} : wd_w;
  wire [15:0] rd_fix_w = (reg_addr_out == `DCS_STAT_ADDR) ?
    (reg_rdata_in | (16'({fault_q}) << `DCS_FAULT_BIT)) : reg_rdata_in;

  // forwarding delay line and serial output
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dly_q <= 16'h0000;
      bit_q <= 4'h0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (cs_fall_w) begin
      dly_q <= 16'h0000;
      bit_q <= 4'h0;
      so_q <= 1'b0;
    end else if (!frame_w) begin
      oe_q <= 1'b0;
    end else if (rise_w) begin
      dly_q <= dly_d;
      bit_q <= bit_q + 4'h1;
    end else if (fall_w) begin
      so_q <= dly_q[15];
      oe_q <= 1'b1;
    end
  end

  // read data capture, in the cycle of the read strobe
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_q <= 16'h0000;
    end else if (reg_rd_out) begin
      rd_q <= rd_fix_w;
    end
  end

  // word-level sequencer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= dcs_pkg::DS_IDLE;
      sg_q <= 1'b0;
      each_q <= 1'b0;
      mine_q <= 1'b0;
      cnt_q <= 16'h0000;
      addr_q <= 15'h0000;
      sum_q <= 16'h0000;
      wcnt_q <= 16'h0000;
      slot_q <= 6'h00;
      reg_addr_out <= 15'h0000;
      reg_wdata_out <= 16'h0000;
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      xfer_ok_out <= 1'b0;
      xfer_bad_out <= 1'b0;
      fault_q <= 1'b0;
      cks_en_q <= 1'b0;
      cfg_hit_q <= 1'b0;
      cfg_val_q <= 1'b0;
    end else begin
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      xfer_ok_out <= 1'b0;
      xfer_bad_out <= 1'b0;
      if (xfer_bad_out) begin
        fault_q <= 1'b1;
      end else if (xfer_ok_out) begin
        fault_q <= 1'b0;
        if (cfg_hit_q) begin
          cks_en_q <= cfg_val_q;
        end
      end
      if (cs_fall_w) begin
        st_q <= dcs_pkg::DS_HDR;
      end else if (!frame_w) begin
        st_q <= dcs_pkg::DS_IDLE;
      end else if (word_w) begin
        unique case (st_q)
          dcs_pkg::DS_HDR: begin
            sg_q <= wd_w[`DCS_S_BIT];
            each_q <= h_each_w;
            mine_q <= h_mine_w;
            cfg_hit_q <= 1'b0;
            if (!h_any_w) begin
              st_q <= dcs_pkg::DS_SKIP;
            end else if (wd_w[`DCS_S_BIT]) begin
              st_q <= dcs_pkg::DS_ADDR;
            end else begin
              st_q <= dcs_pkg::DS_CNT;
            end
          end
          dcs_pkg::DS_CNT: begin
            cnt_q <= wd_w;
            st_q <= dcs_pkg::DS_ADDR;
          end
          dcs_pkg::DS_ADDR: begin
            addr_q <= wd_w[14:0];
            sum_q <= wd_w;
            wcnt_q <= 16'h0000;
            slot_q <= 6'h00;
            if (wd_w[`DCS_RW_BIT]) begin
              if (mine_q) begin
                reg_addr_out <= wd_w[14:0];
                reg_rd_out <= 1'b1;
                st_q <= dcs_pkg::DS_RSLOT;
              end else begin
                st_q <= dcs_pkg::DS_SKIP;
              end
            end else if (n_w == 16'h0000) begin
              st_q <= need_cks_w ? dcs_pkg::DS_CSUM : dcs_pkg::DS_SKIP;
              xfer_ok_out <= ~need_cks_w;
            end else begin
              st_q <= dcs_pkg::DS_DATA;
            end
          end
          dcs_pkg::DS_DATA: begin
            if (take_w) begin
              reg_addr_out <= waddr_w;
              reg_wdata_out <= wd_w;
              reg_wr_out <= 1'b1;
              sum_q <= sum_nx_w;
              if (waddr_w == `DCS_CFG_ADDR) begin
                cfg_hit_q <= 1'b1;
                cfg_val_q <= wd_w[`DCS_CKS_BIT];
              end
            end
            if (last_w) begin
              wcnt_q <= 16'h0000;
              slot_q <= slot_q + 6'h01;
              if (take_w) begin
                st_q <= need_cks_w ? dcs_pkg::DS_CSUM : dcs_pkg::DS_SKIP;
                xfer_ok_out <= ~need_cks_w;
              end
            end else begin
              wcnt_q <= wcnt_q + 16'h0001;
            end
          end
          dcs_pkg::DS_CSUM: begin
            xfer_ok_out <= cks_ok_w;
            xfer_bad_out <= ~cks_ok_w;
            st_q <= dcs_pkg::DS_SKIP;
          end
          dcs_pkg::DS_RSLOT: begin
            xfer_ok_out <= sub_w;
            xfer_bad_out <= ~sub_w;
            st_q <= dcs_pkg::DS_SKIP;
          end
          dcs_pkg::DS_SKIP: begin
            st_q <= dcs_pkg::DS_SKIP;
          end
          dcs_pkg::DS_IDLE: begin
            st_q <= dcs_pkg::DS_IDLE;
          end
        endcase
      end
    end
  end

  assign link.serial_output = so_q;
  assign link.serial_output_oe = oe_q;
  assign checksum_fault_out = fault_q;
  assign checksum_en_out = cks_en_q;
  assign frame_sync_out = fs_s[1] & ~fs_s[2];
endmodule

// [dcs_host_end.sv]
// host controller end of the daisy-chain command port
`include "dcs_defs.svh"
`timescale 1ns/100ps
module dcs_host_end (
  input wire logic clk_in,
  input wire logic arst_n_in,
  dcs_link_if.host link,
  input wire logic [3:0] sw_addr_in,
  input wire logic [15:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [15:0] sw_rdata_out
);
  dcs_pkg::dcs_host_state_t st_q;
  logic [2:0] half_q;
  logic [3:0] bit_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [7:0] dum_q;
  logic end_q;
  logic cs_q;
  logic sclk_q;
  logic [15:0] sum_q;
  logic err_q;
  logic [1:0] widx_q;
  logic hdr_bc_q;
  logic hdr_sg_q;
  logic [4:0] sync_cnt_q;
  logic sync_q;
  logic [1:0] so_s;

  wire idle_w = (st_q == dcs_pkg::HS_IDLE);
  wire tick_w = (half_q == 3'(`DCS_HALF_CYC - 1));
  wire wr_tx_w = sw_wr_in & (sw_addr_in == `DCS_H_TX) & idle_w;
  wire wr_ctl_w = sw_wr_in & (sw_addr_in == `DCS_H_CTRL);
  wire end_w = wr_ctl_w & idle_w & sw_wdata_in[`DCS_H_END_BIT];
  wire [7:0] dum_w = sw_wdata_in[`DCS_H_DUM_HI:`DCS_H_DUM_LO];
  wire [1:0] aidx_w = hdr_sg_q ? 2'h1 : 2'h2;
  // a read may not be broadcast: abort the frame instead of sending
  wire bad_rd_w = wr_tx_w & (widx_q == aidx_w) & hdr_bc_q &
                  sw_wdata_in[`DCS_RW_BIT];
  wire word_done_w = tick_w & sclk_q & (bit_q == 4'hf);
  wire [15:0] neg_sum_w = 16'h0000 - sum_q;
  wire [15:0] stat_w = {13'h0000, err_q, ~cs_q, ~idle_w};
  wire [15:0] rsel_w = (sw_addr_in == `DCS_H_CTRL) ? stat_w :
                       (sw_addr_in == `DCS_H_RX) ? rx_q :
                       (sw_addr_in == `DCS_H_CSUM) ? neg_sum_w : 16'h0000;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      so_s <= 2'h0;
      sw_rdata_out <= 16'h0000;
    end else begin
      so_s <= {so_s[0], link.serial_output};
      sw_rdata_out <= sw_rd_in ? rsel_w : 16'h0000;
    end
  end

  // frame sync pulse, held for the least pulse width
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_cnt_q <= 5'h00;
      sync_q <= 1'b0;
    end else if (wr_ctl_w & sw_wdata_in[`DCS_H_SYNC_BIT]) begin
      sync_cnt_q <= 5'(`DCS_SYNC_CYC);
      sync_q <= 1'b1;
    end else if (sync_cnt_q != 5'h00) begin
      sync_cnt_q <= sync_cnt_q - 5'h01;
      sync_q <= (sync_cnt_q != 5'h01);
    end
  end

  // running checksum over words written to TX since the last clear, including a refused broadcast read that is not sent
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sum_q <= 16'h0000;
      err_q <= 1'b0;
    end else begin
      if (sw_wr_in & (sw_addr_in == `DCS_H_CSUM)) begin
        sum_q <= 16'h0000;
      end else if (wr_tx_w) begin
        sum_q <= sum_q + sw_wdata_in;
      end
      if (bad_rd_w) begin
        err_q <= 1'b1;
      end else if (wr_ctl_w & sw_wdata_in[`DCS_H_ERRCLR_BIT]) begin
        err_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= dcs_pkg::HS_IDLE;
      half_q <= 3'h0;
      bit_q <= 4'h0;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      dum_q <= 8'h00;
      end_q <= 1'b0;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      widx_q <= 2'h0;
      hdr_bc_q <= 1'b0;
      hdr_sg_q <= 1'b0;
    end else begin
      half_q <= (idle_w | tick_w) ? 3'h0 : half_q + 3'h1;
      unique case (st_q)
        dcs_pkg::HS_IDLE: begin
          if (bad_rd_w) begin
            st_q <= dcs_pkg::HS_TAIL;
          end else if (wr_tx_w) begin
            tx_q <= sw_wdata_in;
            cs_q <= 1'b0;
            st_q <= cs_q ? dcs_pkg::HS_LEAD : dcs_pkg::HS_SHIFT;
            if (widx_q == 2'h0) begin
              hdr_bc_q <= sw_wdata_in[`DCS_B_BIT];
              hdr_sg_q <= sw_wdata_in[`DCS_S_BIT];
            end
            if (widx_q != 2'h3) begin
              widx_q <= widx_q + 2'h1;
            end
          end else if (end_w) begin
            tx_q <= 16'h0000;
            dum_q <= dum_w;
            end_q <= 1'b1;
            st_q <= (dum_w != 8'h00) & ~cs_q ? dcs_pkg::HS_SHIFT
                                              : dcs_pkg::HS_TAIL;
          end
        end
        dcs_pkg::HS_LEAD: begin
          if (tick_w) begin
            st_q <= dcs_pkg::HS_SHIFT;
          end
        end
        dcs_pkg::HS_SHIFT: begin
          if (tick_w & !sclk_q) begin
            sclk_q <= 1'b1;
          end else if (tick_w) begin
            sclk_q <= 1'b0;
            rx_q <= {rx_q[14:0], so_s[1]};
            tx_q <= {tx_q[14:0], 1'b0};
            bit_q <= bit_q + 4'h1;
            if (word_done_w & (dum_q > 8'h01)) begin
              dum_q <= dum_q - 8'h01;
            end else if (word_done_w) begin
              dum_q <= 8'h00;
              st_q <= end_q ? dcs_pkg::HS_TAIL : dcs_pkg::HS_IDLE;
            end
          end
        end
        dcs_pkg::HS_TAIL: begin
          if (tick_w) begin
            cs_q <= 1'b1;
            end_q <= 1'b0;
            widx_q <= 2'h0;
            st_q <= dcs_pkg::HS_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_q;
  assign link.serial_input = tx_q[15];
  assign link.frame_sync = sync_q;
endmodule

// [dcs_link_props.sv]
// concurrent checks on the serial link between host and device ends
`timescale 1ns/100ps
module dcs_link_props (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_input,
  input wire logic serial_output,
  input wire logic serial_output_oe,
  input wire logic frame_sync
);
  logic [5:0] fs_cnt_q;
  logic [5:0] fs_cnt_d;

  // length of the current sync pulse, so its width can be checked exactly
  assign fs_cnt_d = frame_sync ? fs_cnt_q + 6'h01 : 6'h00;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fs_cnt_q <= 6'h00;
    end else begin
      fs_cnt_q <= fs_cnt_d;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock high outside a frame");
  lead_half_a: assert property ($fell(cs_n) |-> !sclk [*4])
    else $error("link clock rose too early after select");
  half_period_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase not four cycles");
  din_stable_a: assert property (sclk && $past(sclk) |-> $stable(serial_input))
    else $error("serial input moved while clock high");
  oe_start_a: assert property ($rose(serial_output_oe) |-> !cs_n && !sclk)
    else $error("output enabled outside a low clock phase");
  dout_fall_a: assert property ($changed(serial_output) && serial_output_oe
    && $past(serial_output_oe) |-> !sclk)
    else $error("serial output changed while clock high");
  oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !serial_output_oe)
    else $error("output not released after select rose");
  fs_width_a: assert property ($fell(frame_sync) |-> fs_cnt_q == 6'h19)
    else $error("frame sync pulse width wrong");

  cover property ($rose(serial_output_oe));
  cover property ($fell(frame_sync));
  cover property ($rose(cs_n));
endmodule

// [daisy_chain_spi_command_port_tb_top.sv]
// self-checking bench joining host end and device end over the link
`include "dcs_defs.svh"
`timescale 1ns/100ps
module daisy_chain_spi_command_port_tb_top;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic [5:0] chain_pos = 6'h01;
  logic [14:0] reg_addr;
  logic [15:0] reg_rdata;
  logic [15:0] reg_wdata;
  logic reg_wr, reg_rd, xfer_ok, xfer_bad, cks_fault, cks_en, fs_pulse;
  logic [30:0] wq[$];
  int n_ok = 0;
  int n_bad = 0;
  int n_fs = 0;
  int cycles = 0;
  int err_count = 0;
  int n_compared = 0;

  dcs_link_if link ();

  dcs_host_end dcs_host_end_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .link(link.host), .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata),
    .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata));
  dcs_dev_end dcs_dev_end_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .link(link.dev), .chain_position_in(chain_pos),
    .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .xfer_ok_out(xfer_ok), .xfer_bad_out(xfer_bad),
    .checksum_fault_out(cks_fault), .checksum_en_out(cks_en),
    .frame_sync_out(fs_pulse));
  dcs_link_props dcs_link_props_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .sclk(link.sclk), .cs_n(link.cs_n), .serial_input(link.serial_input),
    .serial_output(link.serial_output),
    .serial_output_oe(link.serial_output_oe), .frame_sync(link.frame_sync));

  always #(`DCS_CLK_NS / 2) clk_in = ~clk_in;

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // user register side: content is a fixed pattern of the location,
  // answered in the cycle of the read strobe as the device samples it
  assign reg_rdata = {1'b0, reg_addr} ^ 16'h5a0c;

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (reg_wr === 1'b1) wq.push_back({reg_addr, reg_wdata});
    if (xfer_ok === 1'b1) n_ok <= n_ok + 1;
    if (xfer_bad === 1'b1) n_bad <= n_bad + 1;
    if (fs_pulse === 1'b1) n_fs <= n_fs + 1;
    if (cycles == 30000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_in);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_in);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  // poll status until the masked busy and frame-open bits clear
  task automatic wait_idle(input logic [1:0] m);
    logic [15:0] s;
    int i;
    s = 16'hffff;
    i = 0;
    while (i < 500 && (s[1:0] & m) !== 2'b00) begin
      sw_read(`DCS_H_CTRL, s);
      i++;
    end
    chk("link idle", {14'h0000, s[1:0] & m}, 16'h0000);
  endtask

  task automatic tx(input logic [15:0] w);
    sw_write(`DCS_H_TX, w);
    wait_idle(2'b01);
  endtask

  task automatic close_frame();
    sw_write(`DCS_H_CTRL, 16'h0001);
    wait_idle(2'b11);
    repeat (8) @(posedge clk_in);
  endtask

  // two zero words trail every frame so results ripple out
  task automatic frame(input logic [15:0] w[$]);
    foreach (w[i]) tx(w[i]);
    tx(16'h0000);
    tx(16'h0000);
    close_frame();
  endtask

  task automatic exp_wr(input logic [14:0] a, input logic [15:0] d);
    logic [30:0] e;
    e = 31'h7fffffff;
    if (wq.size() > 0) e = wq.pop_front();
    chk("write location", {1'b0, e[30:16]}, {1'b0, a});
    chk("write data", e[15:0], d);
  endtask

  initial begin
    logic [15:0] rx;
    int ok0;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    frame('{16'h4100, 16'h0002, 16'h000f});
    exp_wr(15'h0002, 16'h000f);
    frame('{16'h4300, 16'h0002, 16'h000f});
    chk("foreign write", 16'(wq.size()), 16'h0000);
    frame('{16'h0100, 16'h0003, 16'h0002, 16'h0003, 16'h0004, 16'h0005});
    for (int i = 0; i < 3; i++) exp_wr(15'(2 + i), 16'(3 + i));
    frame('{16'hc000, 16'h0007, 16'h1234});
    exp_wr(15'h0007, 16'h1234);
    frame('{16'h8000, 16'h0002, 16'h0010, 16'haaaa, 16'hbbbb});
    exp_wr(15'h0010, 16'haaaa);
    exp_wr(15'h0011, 16'hbbbb);
    frame('{16'hff00, 16'h0020, 16'h1111, 16'h2222});
    exp_wr(15'h0020, 16'h1111);
    frame('{16'hbf00, 16'h0002, 16'h0030, 16'h0a01, 16'h0a02, 16'h0b01});
    exp_wr(15'h0030, 16'h0a01);
    exp_wr(15'h0031, 16'h0a02);
    chk("extra writes", 16'(wq.size()), 16'h0000);
    // second chain member takes the second slot of a per-device broadcast
    chain_pos <= 6'h02;
    frame('{16'hff00, 16'h0020, 16'h1111, 16'h2222});
    exp_wr(15'h0020, 16'h2222);
    chk("slot writes", 16'(wq.size()), 16'h0000);
    chain_pos <= 6'h01;
    tx(16'h4100);
    sw_read(`DCS_H_RX, rx);
    chk("first slot", rx, 16'h0000);
    tx(16'h8002);
    sw_read(`DCS_H_RX, rx);
    chk("forwarded header", rx, 16'h4100);
    tx(16'h0000);
    sw_read(`DCS_H_RX, rx);
    chk("forwarded location", rx, 16'h0002);
    tx(16'h0000);
    sw_read(`DCS_H_RX, rx);
    chk("read content", rx, 16'h5a0e);
    close_frame();
    chk("write on read", 16'(wq.size()), 16'h0000);
    tx(16'hc000);
    sw_write(`DCS_H_TX, 16'h8002);
    wait_idle(2'b11);
    sw_read(`DCS_H_CTRL, rx);
    chk("broadcast read refused", rx, 16'h0004);
    sw_write(`DCS_H_CTRL, 16'h0004);
    sw_read(`DCS_H_CTRL, rx);
    chk("error cleared", rx, 16'h0000);
    chk("refused read writes", 16'(wq.size()), 16'h0000);
    frame('{16'h4100, 16'h0001, 16'h0001});
    exp_wr(15'h0001, 16'h0001);
    chk("checksum mode", {15'h0000, cks_en}, 16'h0001);
    ok0 = n_ok;
    tx(16'h4100);
    sw_write(`DCS_H_CSUM, 16'h0000);
    tx(16'h0002);
    tx(16'h0003);
    sw_read(`DCS_H_CSUM, rx);
    chk("host checksum", rx, 16'hfffb);
    tx(rx);
    tx(16'h0000);
    tx(16'h0000);
    close_frame();
    chk("accepted", 16'(n_ok - ok0), 16'h0001);
    wq.delete();
    frame('{16'h4100, 16'h0002, 16'h0003, 16'h0000});
    chk("rejected", 16'(n_bad), 16'h0001);
    chk("fault flag", {15'h0000, cks_fault}, 16'h0001);
    tx(16'h4100);
    tx(16'h83ff);
    tx(16'h7c01);
    tx(16'h0000);
    sw_read(`DCS_H_RX, rx);
    chk("fault in status", rx, 16'h59fb);
    close_frame();
    wq.delete();
    tx(16'h4100);
    tx(16'h8002);
    tx(16'h7ffe);
    tx(16'h0000);
    sw_read(`DCS_H_RX, rx);
    chk("checked read", rx, 16'h5a0e);
    close_frame();
    frame('{16'h4100, 16'h0002, 16'h0003, 16'hfffb});
    chk("fault cleared", {15'h0000, cks_fault}, 16'h0000);
    sw_write(`DCS_H_CTRL, 16'h0002);
    repeat (40) @(posedge clk_in);
    chk("sync pulses", 16'(n_fs), 16'h0001);
    complete_run();
  end
endmodule
